// ===== alk_map.svh
/*
  Constants of the key builder: register offsets, control bit positions,
  key type codes, key widths and word counts, field widths and the
  mode-3 ingress bitmap layout.
  Assumes inclusion by bare name from the modules; the package does not include it.
*/
`ifndef ALK_MAP_SVH
`define ALK_MAP_SVH

// ********************
// Register map
// ********************
`define ALK_OFS_CTRL 8'h00
`define ALK_OFS_PAG_IDX 8'h04
`define ALK_OFS_PAG_DATA 8'h08
`define ALK_OFS_STATUS 8'h0C
`define ALK_CTRL_W 5
`define ALK_CTRL_RST 5'h00
`define ALK_CTRL_MASQ 0
`define ALK_CTRL_CPU 1
`define ALK_CTRL_VD 2
`define ALK_CTRL_LBK3 3
`define ALK_CTRL_SEC 4
`define ALK_PAG_RST 8'h00

// ********************
// Key formats
// ********************
`define ALK_X8_TW 4
`define ALK_X16_TW 2
`define ALK_X8_MAC 4'h0
`define ALK_X8_ARP 4'h3
`define ALK_X8_TCP 4'h4
`define ALK_X8_OTH 4'h5
`define ALK_X8_CUSB 4'h8
`define ALK_X8_V6 4'h9
`define ALK_X16_T7 2'h1
`define ALK_X16_CUSA 2'h2
`define ALK_LEN_V4 10'h058
`define ALK_LEN_MAC 10'h10F
`define ALK_LEN_ARP 10'h0D2
`define ALK_LEN_TCP 10'h11B
`define ALK_LEN_OTH 10'h112
`define ALK_LEN_CUSB 10'h11C
`define ALK_LEN_V6 10'h11C
`define ALK_LEN_T7 10'h237
`define ALK_LEN_CUSA 10'h222
`define ALK_WORDS_X4 5'h04
`define ALK_WORDS_X8 5'h08
`define ALK_WORDS_X16 5'h10

// ********************
// Fields
// ********************
`define ALK_PAG_W 8
`define ALK_MODE_W 2
`define ALK_MASK_W 53
`define ALK_PORT_W 6
`define ALK_VID_W 12
`define ALK_MC_BIT 40
`define ALK_MODE_DEF 2'h0
`define ALK_MODE_LBK 2'h1
`define ALK_MODE_MASQ 2'h2
`define ALK_MODE_SPEC 2'h3
`define ALK_M3_SRC_LO 4
`define ALK_M3_PT_LO 44
`define ALK_M3_PT_W 5
`define ALK_M3_ACT_LO 49
`define ALK_M3_ACT_W 3
`define ALK_ACT_MASQ 3'h1
`endif

// ===== alk_pkg.sv
/*
  Types of the key builder: key kinds and the bus slave state.
  Assumes nothing beyond the constants header.
*/
package alk_pkg;
  typedef enum logic [3:0] {
    ALK_KIND_V4 = 4'h0,
    ALK_KIND_MAC = 4'h1,
    ALK_KIND_ARP = 4'h2,
    ALK_KIND_TCP = 4'h3,
    ALK_KIND_OTH = 4'h4,
    ALK_KIND_CUSB = 4'h5,
    ALK_KIND_V6 = 4'h6,
    ALK_KIND_T7 = 4'h7,
    ALK_KIND_CUSA = 4'h8
  } alk_kind_e;
  typedef enum logic {
    ALK_BUS_IDLE = 1'b0,
    ALK_BUS_DONE = 1'b1
  } alk_bus_e;
endpackage

// ===== alk_mask_build.sv
/*
  Ingress mask mode choice and ingress port bitmap, combinational.
  Assumes frame attributes from classification logic on the same clock.
*/
`timescale 1ns/1ns
`include "alk_map.svh"
module alk_mask_build #(
  parameter logic [5:0] HOST0 = 6'h35,
  parameter logic [5:0] HOST1 = 6'h36,
  parameter logic [5:0] VDEV0 = 6'h37,
  parameter logic [5:0] VDEV1 = 6'h38
) (
  input wire logic [`ALK_CTRL_W-1:0] ctrl,
  input wire logic [`ALK_PORT_W-1:0] phys_port,
  input wire logic [`ALK_PORT_W-1:0] src_port,
  input wire logic [`ALK_PORT_W-1:0] loop_port,
  input wire logic injected,
  input wire logic loopback,
  input wire logic [`ALK_M3_PT_W-1:0] pipe_pt,
  input wire logic [`ALK_M3_ACT_W-1:0] pipe_act,
  output logic [`ALK_MODE_W-1:0] mode,
  output logic [`ALK_MASK_W-1:0] bitmap
);
  logic masq;
  logic vdev;

  function automatic logic [`ALK_MASK_W-1:0] one_hot(
    input logic [`ALK_PORT_W-1:0] p);
    one_hot = '0;
    if (p < `ALK_PORT_W'(`ALK_MASK_W)) one_hot[p] = 1'b1;
  endfunction

  assign masq = (injected && src_port != phys_port) ||
                pipe_act == `ALK_ACT_MASQ;
  assign vdev = phys_port == VDEV0 || phys_port == VDEV1;

  // Later assignments win, so the highest qualifying mode is taken
  always_comb begin
    mode = `ALK_MODE_DEF;
    if (loopback) mode = `ALK_MODE_LBK;
    if (ctrl[`ALK_CTRL_MASQ] && masq) mode = `ALK_MODE_MASQ;
    if ((ctrl[`ALK_CTRL_CPU] && injected) ||
        (ctrl[`ALK_CTRL_VD] && vdev) ||
        (ctrl[`ALK_CTRL_LBK3] && loopback)) begin
      mode = `ALK_MODE_SPEC;
    end
  end

  always_comb begin
    bitmap = '0;
    case (mode)
      `ALK_MODE_DEF: bitmap = one_hot(phys_port);
      `ALK_MODE_LBK: bitmap = one_hot(loop_port);
      `ALK_MODE_MASQ: bitmap = one_hot(src_port);
      `ALK_MODE_SPEC: begin
        bitmap[0] = phys_port == HOST0;
        bitmap[1] = phys_port == HOST1;
        bitmap[2] = phys_port == VDEV0;
        bitmap[3] = phys_port == VDEV1;
        bitmap[`ALK_M3_SRC_LO +: `ALK_PORT_W] = src_port;
        bitmap[`ALK_M3_PT_LO +: `ALK_M3_PT_W] = pipe_pt;
        bitmap[`ALK_M3_ACT_LO +: `ALK_M3_ACT_W] = pipe_act;
      end
      default: bitmap = '0;
    endcase
  end
endmodule

// ===== alk_frame_flags.sv
/*
  Destination address flags and key VID choice, combinational.
  Assumes classification results on the same clock.
*/
`timescale 1ns/1ns
`include "alk_map.svh"
module alk_frame_flags (
  input wire logic [47:0] dmac,
  input wire logic first,
  input wire logic sec_en,
  input wire logic routable,
  input wire logic service,
  input wire logic [`ALK_VID_W-1:0] class_vid,
  input wire logic [`ALK_VID_W-1:0] ingress_router_leg_vid,
  input wire logic [`ALK_VID_W-1:0] egress_router_leg_vid,
  output logic mc,
  output logic bc,
  output logic [`ALK_VID_W-1:0] vid
);
  assign mc = dmac[`ALK_MC_BIT];
  assign bc = &dmac;
  assign vid = (sec_en && routable && !service) ?
               (first ? ingress_router_leg_vid : egress_router_leg_vid) : class_vid;
endmodule

// ===== alk_key_builder.sv
/*
  Search key builder for the access-control match stage: packs type
  selector, lookup flag, policy tag, ingress mask mode and bitmap and
  destination flags in order from bit 0, with APB configuration.
  Assumes requests from classification logic on CLOCK, one cycle wide,
  and a match memory that takes the key one cycle later.
*/
`timescale 1ns/1ns
`include "alk_map.svh"

// Contract
// - Four-word format; IPv4 VLAN key 88 bits
// - Eight-word format keys with their widths
// - Sixteen-word format: seven-tuple 567, custom A 546
// - Fields packed contiguously from bit 0
// - MAC key: type bits 3:0, flag bit 4
// - Type selector codes per key kind
// - Lookup flag set first, cleared second
// - Policy tag in every key, per-port default
// - Mask mode 0 default, 1 loopback
// - Mode 2 for masqueraded frames when enabled
// - Mode 3 for host, virtual device, loopback
// - Highest qualifying mode wins
// - One bitmap bit per port by mode
// - Mode 3 bitmap layout
// - Multicast flag from destination bit 40
// - Broadcast flag for all-ones destination
// - Router leg VID choice for second lookup
module alk_key_builder
  import alk_pkg::*;
#(
  parameter int WORD_W = 36,
  parameter int KEY_W = 16 * WORD_W
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REQ_VALID,
  input wire logic [3:0] REQ_KIND,
  input wire logic REQ_FIRST,
  input wire logic [`ALK_PORT_W-1:0] REQ_PORT,
  input wire logic [`ALK_PORT_W-1:0] REQ_SRC_PORT,
  input wire logic [`ALK_PORT_W-1:0] REQ_LOOP_PORT,
  input wire logic REQ_INJECTED,
  input wire logic REQ_LOOPBACK,
  input wire logic [`ALK_M3_PT_W-1:0] REQ_PIPE_PT,
  input wire logic [`ALK_M3_ACT_W-1:0] REQ_PIPE_ACT,
  input wire logic [47:0] REQ_DMAC,
  input wire logic REQ_ROUTABLE,
  input wire logic REQ_SERVICE,
  input wire logic [`ALK_VID_W-1:0] REQ_VID,
  input wire logic [`ALK_VID_W-1:0] REQ_INGRESS_ROUTER_LEG_VID,
  input wire logic [`ALK_VID_W-1:0] REQ_EGRESS_ROUTER_LEG_VID,
  input wire logic REQ_PAG_OVR,
  input wire logic [`ALK_PAG_W-1:0] REQ_PAG,
  output logic KEY_VALID,
  output logic [KEY_W-1:0] KEY,
  output logic [4:0] KEY_WORDS,
  output logic [9:0] KEY_LEN,
  output logic [`ALK_VID_W-1:0] KEY_VID
);

  // ********************
  // Declarations
  // ********************
  alk_bus_e st_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [`ALK_CTRL_W-1:0] ctrl_q;
  logic [`ALK_PORT_W-1:0] pag_idx_q;
  logic [`ALK_PAG_W-1:0] pag_tab [`ALK_MASK_W];
  logic [15:0] cnt_q;
  logic [`ALK_MODE_W-1:0] mode_q;
  logic key_valid_q;
  logic [KEY_W-1:0] key_q;
  logic [4:0] words_q;
  logic [9:0] len_q;
  logic [`ALK_VID_W-1:0] vid_q;
  logic [`ALK_MODE_W-1:0] mode;
  logic [`ALK_MASK_W-1:0] bitmap;
  logic mc;
  logic bc;
  logic [`ALK_VID_W-1:0] vid;
  logic [`ALK_PAG_W-1:0] policy_group_tag;
  logic [`ALK_PAG_W-1:0] pag_rd;
  logic access;
  logic hit;
  logic [31:0] rd_val;
  alk_kind_e kind;

  // ********************
  // Key packing
  // ********************
  function automatic logic [KEY_W-1:0] pack(
    input alk_kind_e k,
    input logic first,
    input logic [`ALK_PAG_W-1:0] tag,
    input logic [`ALK_MODE_W-1:0] md,
    input logic [`ALK_MASK_W-1:0] map,
    input logic mcf,
    input logic bcf);
    int pos;
    logic [KEY_W-1:0] key;
    key = '0;
    pos = 0;
    case (k)
      ALK_KIND_MAC: key[`ALK_X8_TW-1:0] = `ALK_X8_MAC;
      ALK_KIND_ARP: key[`ALK_X8_TW-1:0] = `ALK_X8_ARP;
      ALK_KIND_TCP: key[`ALK_X8_TW-1:0] = `ALK_X8_TCP;
      ALK_KIND_OTH: key[`ALK_X8_TW-1:0] = `ALK_X8_OTH;
      ALK_KIND_CUSB: key[`ALK_X8_TW-1:0] = `ALK_X8_CUSB;
      ALK_KIND_V6: key[`ALK_X8_TW-1:0] = `ALK_X8_V6;
      ALK_KIND_T7: key[`ALK_X16_TW-1:0] = `ALK_X16_T7;
      ALK_KIND_CUSA: key[`ALK_X16_TW-1:0] = `ALK_X16_CUSA;
      default: key = '0;
    endcase
    case (k)
      // The IPv6 VLAN key keeps its type code but skips the mask fields
      ALK_KIND_V4: pos = 0;
      ALK_KIND_T7, ALK_KIND_CUSA: pos = `ALK_X16_TW;
      default: pos = `ALK_X8_TW;
    endcase
    key[pos] = first;
    pos = pos + 1;
    key[pos +: `ALK_PAG_W] = tag;
    pos = pos + `ALK_PAG_W;
    if (k != ALK_KIND_V4 && k != ALK_KIND_V6) begin
      key[pos +: `ALK_MODE_W] = md;
      pos = pos + `ALK_MODE_W;
      key[pos +: `ALK_MASK_W] = map;
      pos = pos + `ALK_MASK_W;
      key[pos] = mcf;
      key[pos + 1] = bcf;
    end
    pack = key;
  endfunction

  function automatic logic [14:0] kind_size(input alk_kind_e k);
    case (k)
      ALK_KIND_V4: kind_size = {`ALK_WORDS_X4, `ALK_LEN_V4};
      ALK_KIND_MAC: kind_size = {`ALK_WORDS_X8, `ALK_LEN_MAC};
      ALK_KIND_ARP: kind_size = {`ALK_WORDS_X8, `ALK_LEN_ARP};
      ALK_KIND_TCP: kind_size = {`ALK_WORDS_X8, `ALK_LEN_TCP};
      ALK_KIND_OTH: kind_size = {`ALK_WORDS_X8, `ALK_LEN_OTH};
      ALK_KIND_CUSB: kind_size = {`ALK_WORDS_X8, `ALK_LEN_CUSB};
      ALK_KIND_V6: kind_size = {`ALK_WORDS_X8, `ALK_LEN_V6};
      ALK_KIND_T7: kind_size = {`ALK_WORDS_X16, `ALK_LEN_T7};
      ALK_KIND_CUSA: kind_size = {`ALK_WORDS_X16, `ALK_LEN_CUSA};
      default: kind_size = {`ALK_WORDS_X4, `ALK_LEN_V4};
    endcase
  endfunction

  // ********************
  // Frame decode
  // ********************
  assign kind = alk_kind_e'(REQ_KIND);

  alk_mask_build u_mask (
    .ctrl(ctrl_q),
    .phys_port(REQ_PORT),
    .src_port(REQ_SRC_PORT),
    .loop_port(REQ_LOOP_PORT),
    .injected(REQ_INJECTED),
    .loopback(REQ_LOOPBACK),
    .pipe_pt(REQ_PIPE_PT),
    .pipe_act(REQ_PIPE_ACT),
    .mode(mode),
    .bitmap(bitmap)
  );

  alk_frame_flags u_flags (
    .dmac(REQ_DMAC),
    .first(REQ_FIRST),
    .sec_en(ctrl_q[`ALK_CTRL_SEC]),
    .routable(REQ_ROUTABLE),
    .service(REQ_SERVICE),
    .class_vid(REQ_VID),
    .ingress_router_leg_vid(REQ_INGRESS_ROUTER_LEG_VID),
    .egress_router_leg_vid(REQ_EGRESS_ROUTER_LEG_VID),
    .mc(mc),
    .bc(bc),
    .vid(vid)
  );

  // Ports outside the bitmap range fall back to the reset tag
  always_comb begin
    pag_rd = `ALK_PAG_RST;
    if (pag_idx_q < `ALK_PORT_W'(`ALK_MASK_W)) pag_rd = pag_tab[pag_idx_q];
    policy_group_tag = `ALK_PAG_RST;
    if (REQ_PAG_OVR) begin
      policy_group_tag = REQ_PAG;
    end else if (REQ_PORT < `ALK_PORT_W'(`ALK_MASK_W)) begin
      policy_group_tag = pag_tab[REQ_PORT];
    end
  end

  // ********************
  // Key output stage
  // ********************
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      key_valid_q <= 1'b0;
      key_q <= '0;
      words_q <= 5'h00;
      len_q <= 10'h000;
      vid_q <= '0;
    end else begin
      key_valid_q <= REQ_VALID;
      if (REQ_VALID) begin
        key_q <= pack(kind, REQ_FIRST, policy_group_tag, mode, bitmap, mc, bc);
        {words_q, len_q} <= kind_size(kind);
        vid_q <= vid;
      end
    end
  end

  // Status view: running key count and the mode of the most recent key
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      cnt_q <= 16'h0000;
      mode_q <= `ALK_MODE_DEF;
    end else if (REQ_VALID) begin
      cnt_q <= cnt_q + 16'h0001;
      mode_q <= mode;
    end
  end

  assign KEY_VALID = key_valid_q;
  assign KEY = key_q;
  assign KEY_WORDS = words_q;
  assign KEY_LEN = len_q;
  assign KEY_VID = vid_q;

  // ********************
  // APB slave
  // ********************
  // One wait state: read data is captured once and held stable
  assign access = PSEL && PENABLE && st_q == ALK_BUS_IDLE;

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (PADDR)
      `ALK_OFS_CTRL: rd_val[`ALK_CTRL_W-1:0] = ctrl_q;
      `ALK_OFS_PAG_IDX: rd_val[`ALK_PORT_W-1:0] = pag_idx_q;
      `ALK_OFS_PAG_DATA: rd_val[`ALK_PAG_W-1:0] = pag_rd;
      `ALK_OFS_STATUS: rd_val = {cnt_q, 14'h0000, mode_q};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      st_q <= ALK_BUS_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        ALK_BUS_IDLE: begin
          if (access) begin
            st_q <= ALK_BUS_DONE;
            pready_q <= 1'b1;
            pslverr_q <= !hit;
            prdata_q <= PWRITE ? 32'h0000_0000 : rd_val;
          end
        end
        ALK_BUS_DONE: begin
          st_q <= ALK_BUS_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
          prdata_q <= 32'h0000_0000;
        end
        default: st_q <= ALK_BUS_IDLE;
      endcase
    end
  end

  // Writes land at the edge that completes the transfer
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ctrl_q <= `ALK_CTRL_RST;
      pag_idx_q <= '0;
      for (int i = 0; i < `ALK_MASK_W; i++) pag_tab[i] <= `ALK_PAG_RST;
    end else if (st_q == ALK_BUS_DONE && PSEL && PENABLE && PWRITE) begin
      case (PADDR)
        `ALK_OFS_CTRL: ctrl_q <= PWDATA[`ALK_CTRL_W-1:0];
        `ALK_OFS_PAG_IDX: pag_idx_q <= PWDATA[`ALK_PORT_W-1:0];
        `ALK_OFS_PAG_DATA: begin
          if (pag_idx_q < `ALK_PORT_W'(`ALK_MASK_W)) begin
            pag_tab[pag_idx_q] <= PWDATA[`ALK_PAG_W-1:0];
          end
        end
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  // ********************
  // Assertions
  // ********************
  property p_v4_fmt;
    @(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && REQ_KIND == ALK_KIND_V4 |=>
      KEY_VALID && KEY_WORDS == `ALK_WORDS_X4 && KEY_LEN == `ALK_LEN_V4;
  endproperty
  a_v4_fmt: assert property (p_v4_fmt) else $error("bad x4 size");

  property p_x8_len;
    @(posedge CLOCK) disable iff (!NRST)
    KEY_VALID && KEY_WORDS == `ALK_WORDS_X8 |->
      KEY_LEN inside {`ALK_LEN_MAC, `ALK_LEN_ARP, `ALK_LEN_TCP,
                      `ALK_LEN_OTH, `ALK_LEN_CUSB};
  endproperty
  a_x8_len: assert property (p_x8_len) else $error("bad x8 size");

  property p_x16_len;
    @(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && REQ_KIND == ALK_KIND_T7 |=>
      KEY_WORDS == `ALK_WORDS_X16 && KEY_LEN == `ALK_LEN_T7;
  endproperty
  a_x16_len: assert property (p_x16_len) else $error("bad x16");

  property p_mac_head;
    @(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && REQ_KIND == ALK_KIND_MAC |=>
      KEY[3:0] == `ALK_X8_MAC && KEY[4] == $past(REQ_FIRST);
  endproperty
  a_mac_head: assert property (p_mac_head) else $error("mac head");

  property p_v4_first;
    @(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && REQ_KIND == ALK_KIND_V4 && REQ_PAG_OVR |=>
      KEY[0] == $past(REQ_FIRST) && KEY[8:1] == $past(REQ_PAG);
  endproperty
  a_v4_first: assert property (p_v4_first) else $error("v4 head");

  property p_mcast;
    @(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && REQ_KIND == ALK_KIND_ARP |=>
      KEY[68] == $past(REQ_DMAC[`ALK_MC_BIT]);
  endproperty
  a_mcast: assert property (p_mcast) else $error("mc flag");

  property p_cpu_mode;
    @(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && REQ_INJECTED && ctrl_q[`ALK_CTRL_CPU] |=>
      mode_q == `ALK_MODE_SPEC;
  endproperty
  a_cpu_mode: assert property (p_cpu_mode) else $error("mode");

  property p_def_mode;
    @(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && !REQ_INJECTED && !REQ_LOOPBACK &&
      REQ_PIPE_ACT != `ALK_ACT_MASQ && ctrl_q == `ALK_CTRL_RST |=>
      mode_q == `ALK_MODE_DEF;
  endproperty
  a_def_mode: assert property (p_def_mode) else $error("mode 0");

  property p_evid;
    @(posedge CLOCK) disable iff (!NRST)
    REQ_VALID && ctrl_q[`ALK_CTRL_SEC] && REQ_ROUTABLE &&
      !REQ_SERVICE && !REQ_FIRST |=> KEY_VID == $past(REQ_EGRESS_ROUTER_LEG_VID);
  endproperty
  a_evid: assert property (p_evid) else $error("vid choice");

  property p_bus_ans;
    @(posedge CLOCK) disable iff (!NRST)
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("apb answer");
endmodule

// ===== alk_match_model.sv
/*
  Match memory stand-in: takes each key when it is offered and keeps
  the last one with its word count, length and VID, plus a key count.
  Assumes the key builder's one-cycle KEY_VALID pulse on the same clock.
*/
`timescale 1ns/1ns
module alk_match_model #(
  parameter int KEY_W = 576
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic key_valid,
  input wire logic [KEY_W-1:0] key,
  input wire logic [4:0] key_words,
  input wire logic [9:0] key_len,
  input wire logic [11:0] key_vid,
  output logic [KEY_W-1:0] entry_q,
  output logic [4:0] words_q,
  output logic [9:0] len_q,
  output logic [11:0] vid_q,
  output logic [15:0] hits_q
);
  // ********************
  // Capture
  // ********************
  // No back-pressure exists, so every pulse must be taken at once
  always_ff @(posedge clock) begin
    if (!nrst) begin
      entry_q <= '0;
      words_q <= 5'h00;
      len_q <= 10'h000;
      vid_q <= 12'h000;
      hits_q <= 16'h0000;
    end else if (key_valid) begin
      entry_q <= key;
      words_q <= key_words;
      len_q <= key_len;
      vid_q <= key_vid;
      hits_q <= hits_q + 16'h0001;
    end
  end
endmodule

// ===== alk_key_builder_tb.sv
/*
  Self-checking bench of the key builder: APB configuration, every key
  kind, mask modes, destination flags and VID choice.
  Assumes the match memory model beside it and the designer's timing.
*/
`timescale 1ns/1ns
module alk_key_builder_tb;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic req_valid, req_first, req_injected, req_loopback;
  logic req_routable, req_service, req_pag_ovr, key_valid;
  logic [3:0] req_kind;
  logic [5:0] req_port, req_src_port, req_loop_port;
  logic [4:0] req_pipe_pt, key_words, mdl_words;
  logic [2:0] req_pipe_act;
  logic [47:0] req_dmac;
  logic [11:0] req_vid, req_ingress_router_leg_vid, req_egress_router_leg_vid, key_vid, mdl_vid;
  logic [7:0] req_pag;
  logic [575:0] key, mdl_key;
  logic [9:0] key_len, mdl_len;
  logic [15:0] mdl_hits;
  int n_errors = 0;
  int samples_checked = 0;
  int n_keys = 0;

  alk_key_builder alk_key_builder_i (.CLOCK(clock), .NRST(nrst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .REQ_VALID(req_valid), .REQ_KIND(req_kind),
    .REQ_FIRST(req_first), .REQ_PORT(req_port),
    .REQ_SRC_PORT(req_src_port), .REQ_LOOP_PORT(req_loop_port),
    .REQ_INJECTED(req_injected), .REQ_LOOPBACK(req_loopback),
    .REQ_PIPE_PT(req_pipe_pt), .REQ_PIPE_ACT(req_pipe_act),
    .REQ_DMAC(req_dmac), .REQ_ROUTABLE(req_routable),
    .REQ_SERVICE(req_service), .REQ_VID(req_vid),
    .REQ_INGRESS_ROUTER_LEG_VID(req_ingress_router_leg_vid), .REQ_EGRESS_ROUTER_LEG_VID(req_egress_router_leg_vid),
    .REQ_PAG_OVR(req_pag_ovr), .REQ_PAG(req_pag),
    .KEY_VALID(key_valid), .KEY(key), .KEY_WORDS(key_words),
    .KEY_LEN(key_len), .KEY_VID(key_vid));
  alk_match_model alk_match_model_i (.clock(clock), .nrst(nrst),
    .key_valid(key_valid), .key(key), .key_words(key_words),
    .key_len(key_len), .key_vid(key_vid), .entry_q(mdl_key),
    .words_q(mdl_words), .len_q(mdl_len), .vid_q(mdl_vid),
    .hits_q(mdl_hits));

  // ********************
  // Shared tasks
  // ********************
  task chk(input logic [63:0] g, input logic [63:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk({32'h0, r}, {32'h0, x}, "read data");
    chk({63'h0, e}, {63'h0, xe}, "slave error");
  endtask
  task send(input logic [3:0] kind, input logic f);
    @(posedge clock);
    req_kind <= kind;
    req_first <= f;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    @(posedge clock);
    chk({63'h0, key_valid}, 64'h1, "key not offered");
    n_keys++;
    @(posedge clock);
    chk({63'h0, key_valid}, 64'h0, "key offered twice");
  endtask
  // Layout check from base b: type, lookup flag, tag, mode, map, flags
  task chk_key(input int b, input logic v, input logic [3:0] ty,
    input logic f, input logic [7:0] tg, input logic [1:0] md,
    input logic [52:0] mp, input logic mc, input logic bc);
    if (b == 4) chk({60'h0, mdl_key[3:0]}, {60'h0, ty}, "type");
    if (b == 2) chk({62'h0, mdl_key[1:0]}, {60'h0, ty}, "type");
    chk({63'h0, mdl_key[b]}, {63'h0, f}, "first flag");
    chk({56'h0, mdl_key[b+1 +: 8]}, {56'h0, tg}, "tag");
    if (v) begin
      chk(64'(mdl_key >> (b + 9) == '0), 64'h1, "vlan key tail");
    end else begin
      chk({62'h0, mdl_key[b+9 +: 2]}, {62'h0, md}, "mode");
      chk({11'h0, mdl_key[b+11 +: 53]}, {11'h0, mp}, "map");
      chk({62'h0, mdl_key[b+64], mdl_key[b+65]},
        {62'h0, mc, bc}, "flags");
      chk(64'(mdl_key >> (b + 66) == '0), 64'h1, "key tail");
    end
  endtask
  function automatic logic [52:0] m3(input logic [3:0] s,
    input logic [5:0] sp, input logic [2:0] act);
    return {1'b0, act, 5'h15, 34'h0, sp, s};
  endfunction

  // ********************
  // Scenarios
  // ********************
  task t_regs();
    rd(8'h00, 32'h0000_0000, 1'b0);
    rd(8'h0C, 32'h0000_0000, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    wr(8'h00, 32'h0000_001F);
    rd(8'h00, 32'h0000_001F, 1'b0);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000, 1'b0);
    wr(8'h04, 32'h0000_0035);
    wr(8'h08, 32'h0000_0077);
    rd(8'h08, 32'h0000_0000, 1'b0);
    wr(8'h00, 32'h0000_0000);
  endtask
  // Expected key length and type code per kind
  function automatic logic [13:0] exp_kind(input int k);
    case (k)
      0: return {10'h058, 4'h0};
      1: return {10'h10F, 4'h0};
      2: return {10'h0D2, 4'h3};
      3: return {10'h11B, 4'h4};
      4: return {10'h112, 4'h5};
      5: return {10'h11C, 4'h8};
      6: return {10'h11C, 4'h9};
      7: return {10'h237, 4'h1};
      default: return {10'h222, 4'h2};
    endcase
  endfunction
  task t_kinds();
    int b;
    logic [13:0] x;
    for (int k = 0; k < 9; k++) begin
      b = (k == 0) ? 0 : (k > 6 ? 2 : 4);
      x = exp_kind(k);
      req_pag <= 8'h5A ^ 8'(k);
      send(4'(k), k[0]);
      chk({59'h0, mdl_words}, b == 2 ? 64'h10 : (k == 0 ? 64'h4 :
        64'h8), "words");
      chk({54'h0, mdl_len}, {54'h0, x[13:4]}, "length");
      chk_key(b, k == 0 || k == 6, x[3:0], k[0], 8'h5A ^ 8'(k), 2'h0,
        53'h8, 1'b1, 1'b0);
    end
    req_pag <= 8'h5A;
  endtask
  task t_pag();
    wr(8'h04, 32'h0000_0003);
    wr(8'h08, 32'h0000_00C3);
    rd(8'h08, 32'h0000_00C3, 1'b0);
    req_pag_ovr <= 1'b0;
    send(4'h1, 1'b1);
    chk({56'h0, mdl_key[12:5]}, 64'hC3, "port tag");
    req_pag_ovr <= 1'b1;
  endtask
  task mcase(input logic [4:0] c, input logic [5:0] ph,
    input logic [5:0] sp, input logic inj, input logic lbk,
    input logic [2:0] act, input logic [1:0] md, input logic [52:0] mp);
    wr(8'h00, {27'h0, c});
    req_port <= ph;
    req_src_port <= sp;
    req_injected <= inj;
    req_loopback <= lbk;
    req_pipe_act <= act;
    send(4'h1, 1'b1);
    chk_key(4, 1'b0, 4'h0, 1'b1, 8'h5A, md, mp, 1'b1, 1'b0);
  endtask
  task t_mask();
    mcase(5'h00, 6'h03, 6'h09, 1, 1, 3'h0, 2'h1, 53'h80);
    mcase(5'h01, 6'h03, 6'h09, 1, 1, 3'h0, 2'h2, 53'h200);
    mcase(5'h01, 6'h03, 6'h0A, 0, 0, 3'h1, 2'h2, 53'h400);
    mcase(5'h02, 6'h35, 6'h09, 1, 0, 3'h6, 2'h3,
      m3(4'h1, 6'h09, 3'h6));
    mcase(5'h04, 6'h37, 6'h09, 0, 0, 3'h6, 2'h3,
      m3(4'h4, 6'h09, 3'h6));
    mcase(5'h09, 6'h38, 6'h0C, 0, 1, 3'h1, 2'h3,
      m3(4'h8, 6'h0C, 3'h1));
    mcase(5'h02, 6'h05, 6'h05, 0, 0, 3'h0, 2'h0, 53'h20);
    rd(8'h0C, {16'(n_keys), 16'h0000}, 1'b0);
  endtask
  task flg(input logic [47:0] d, input logic mc, input logic bc);
    req_dmac <= d;
    send(4'h2, 1'b0);
    chk({62'h0, mdl_key[68], mdl_key[69]}, {62'h0, mc, bc}, "dmac");
  endtask
  task t_vid(input logic [4:0] c, input logic sv, input logic f,
    input logic [11:0] x);
    wr(8'h00, {27'h0, c});
    req_service <= sv;
    send(4'h0, f);
    chk({52'h0, mdl_vid}, {52'h0, x}, "vid");
  endtask

  // ********************
  // Clock, reset, main sequence
  // ********************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {req_valid, req_kind, req_first, req_injected, req_loopback} = '0;
    {req_src_port, req_loop_port, req_service, req_pag_ovr} = '0;
    req_port = 6'h03;
    req_loop_port = 6'h07;
    req_pipe_pt = 5'h15;
    req_pipe_act = 3'h0;
    req_dmac = 48'h0100_0000_0000;
    req_routable = 1'b1;
    req_vid = 12'h111;
    req_ingress_router_leg_vid = 12'h222;
    req_egress_router_leg_vid = 12'h333;
    req_pag_ovr = 1'b1;
    req_pag = 8'h5A;
    repeat (4) @(posedge clock);
    chk({62'h0, key_valid, pready}, 64'h0, "outputs in reset");
    nrst <= 1'b1;
    t_regs();
    t_kinds();
    t_pag();
    t_mask();
    flg(48'hFFFF_FFFF_FFFF, 1'b1, 1'b1);
    flg(48'hFEFF_FFFF_FFFF, 1'b0, 1'b0);
    t_vid(5'h10, 1'b0, 1'b1, 12'h222);
    t_vid(5'h10, 1'b0, 1'b0, 12'h333);
    t_vid(5'h10, 1'b1, 1'b0, 12'h111);
    t_vid(5'h00, 1'b0, 1'b0, 12'h111);
    chk({48'h0, mdl_hits}, 64'(n_keys), "keys taken");
    end_of_test();
  end
endmodule
